// ### src/sel_pkg.sv
// Constants, types and helpers shared by the serial EEPROM configuration loader.
// Summary of operation
// - Fundamental reset loads prescaler for 100 KHz when slow strap set, else 400 KHz.
// - Load runs on fundamental or hot reset only in modes using EEPROM init.
// - Bus address is 101 followed by the four address pins, then read/write bit.
// - Bytes read from address zero until done block ends or address wraps.
// - Every register update is one full 32-bit word write.
// - Block address is a word address; byte address appends two zero bits.
// - Single block: address low, type plus address high, four data bytes LSB first.
// - Type one block carries start address, word count, then that many data words.
// - Type three block holds checksum and type and ends the load.
// - Write to an unmapped address is dropped and flags unmapped_write_flag.
// - Shared bus needs an arbitrating external master; split buses need none.
// - The slave port reads and writes every software-visible register.
// - Each interface has one clock pin, one data pin, four address pins.
// - Sixteen-bit byte addressing covers parts from 4 KB to 64 KB.
// - All bytes read, checksum included, must sum to 0xFF in eight bits.
// - Any error aborts and records cause, then sets hold_in_reset_flag and done in the same cycle.
// - Block type two is invalid; flag bad_block_error_flag and abort.
// - ignore_checksum_errors suppresses checksum mismatch as an error.
package sel_pkg;

  localparam int          CLK_KHZ    = 250000;
  localparam int          SLOW_KHZ   = 100;
  localparam int          FAST_KHZ   = 400;
  localparam int          QTR_PER_BIT = 4;
  localparam logic [15:0] PRESC_SLOW =
    16'((CLK_KHZ + QTR_PER_BIT * SLOW_KHZ - 1) / (QTR_PER_BIT * SLOW_KHZ));
  localparam logic [15:0] PRESC_FAST =
    16'((CLK_KHZ + QTR_PER_BIT * FAST_KHZ - 1) / (QTR_PER_BIT * FAST_KHZ));

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STAT      = 8'h04;
  localparam logic [7:0]  OFS_SWITCH_CONTROL_REG     = 8'h08;
  localparam int          CTRL_IGN_BIT  = 16;
  localparam int          STAT_BUSY_BIT = 4;
  localparam int          SWITCH_CONTROL_REG_HOLD_BIT = 0;

  localparam logic [2:0]  DEV_ADDR_TOP = 3'h5;
  localparam logic        RW_WRITE     = 1'b0;
  localparam logic        RW_READ      = 1'b1;
  localparam logic [15:0] EE_START     = 16'h0000;
  localparam logic [15:0] EE_LAST      = 16'hffff;
  localparam logic [3:0]  BIT_ACK      = 4'h8;
  localparam logic [1:0]  DW_LAST_BYTE = 2'h3;
  localparam logic [7:0]  SUM_GOOD     = 8'hff;

  localparam logic [1:0]  TYPE_SINGLE = 2'h0;
  localparam logic [1:0]  TYPE_SEQ    = 2'h1;
  localparam logic [1:0]  TYPE_BAD    = 2'h2;
  localparam logic [1:0]  TYPE_DONE   = 2'h3;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} sel_op_t;
  typedef enum logic [1:0] {Q_SETUP, Q_RISE, Q_HIGH, Q_FALL} sel_qtr_t;

  typedef struct packed {
    logic        nack;
    logic        bad_block;
    logic        unmapped;
    logic        done;
  } sel_stat_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
  } sel_cfg_wr_t;

  function automatic logic [7:0] dev_byte(input logic [3:0] pins, input logic rw);
    dev_byte = {DEV_ADDR_TOP, pins, rw};
  endfunction

endpackage

// ### src/sel_sync.sv
// Three-stage input synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/100ps
`default_nettype none
module sel_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;
  logic [W-1:0] agree;

  always_comb
  begin
    agree = ~(s2_q ^ s3_q);
    out_d = (agree & s3_q) | (~agree & out_q);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q  <= RST;
      s2_q  <= RST;
      s3_q  <= RST;
      out_q <= RST;
    end
    else
    begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule
`default_nettype wire

// ### src/sel_tick.sv
// Quarter-bit tick generator driven by the bus clock prescaler.
`timescale 1ns/100ps
`default_nettype none
module sel_tick #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] period,
  input  wire logic         run,
  output logic              tick
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  always_comb
  begin
    cnt_d  = cnt_q + W'(1);
    tick_d = 1'b0;
    if (!run)
    begin
      cnt_d = '0;
    end
    else if (cnt_q + W'(1) >= period)
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// ### src/sel_loader.sv
// Serial EEPROM configuration loader: bus master engine, block parser and registers.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module sel_loader #(
  parameter logic [15:0] EEPROM_MODES = 16'h0001
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 fund_reset_start,
  input  wire logic                 hot_reset_start,
  input  wire logic [3:0]           switch_operating_mode,
  input  wire logic                 master_slow_mode_strap,
  input  wire logic [3:0]           eeprom_address_pins,
  input  wire logic                 scl_i,
  output logic                      scl_o,
  output logic                      scl_oe,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  output sel_pkg::sel_cfg_wr_t      cfg_wr,
  output logic                      cfg_wr_valid,
  input  wire logic                 cfg_wr_mapped,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata,
  output logic                      load_busy,
  output logic                      eeprom_done,
  output logic                      hold_in_reset
);

  typedef enum logic [3:0] {L_IDLE, L_START1, L_DEVW, L_MHI, L_MLO, L_START2, L_DEVR,
                            L_READ, L_LAST, L_STOP, L_FIN} sel_seq_t;
  typedef enum logic [2:0] {P_ALO, P_AHI, P_CLO, P_CHI, P_DATA} sel_parse_t;

  // ************************************************************
  // Pin sampling and bit timing.
  // ************************************************************

  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       strap_s;
  logic       tick;
  logic [15:0] presc_q;
  logic        e_act_q;

  sel_sync #(
    .W   (3),
    .RST (3'h3)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     ({master_slow_mode_strap, sda_i, scl_i}),
    .dout    (pins_s)
  );

  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign strap_s = pins_s[2];

  sel_tick #(
    .W (16)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .period  (presc_q),
    .run     (e_act_q),
    .tick    (tick)
  );

  // ************************************************************
  // Byte engine: start, stop, write byte, read byte.
  // ************************************************************

  sel_pkg::sel_op_t  e_op_q;
  sel_pkg::sel_op_t  e_op_d;
  sel_pkg::sel_qtr_t e_qtr_q;
  sel_pkg::sel_qtr_t e_qtr_d;
  sel_pkg::sel_op_t  cmd_op;
  logic        e_act_d;
  logic [3:0]  e_bit_q;
  logic [3:0]  e_bit_d;
  logic [7:0]  e_sh_q;
  logic [7:0]  e_sh_d;
  logic        e_ack_q;
  logic        e_ack_d;
  logic        e_nack_q;
  logic        e_nack_d;
  logic        e_done_q;
  logic        e_done_d;
  logic        scl_oe_q;
  logic        scl_oe_d;
  logic        sda_oe_q;
  logic        sda_oe_d;
  logic        cmd_go;
  logic [7:0]  cmd_byte;
  logic        cmd_ack;

  // Whether data is pulled low during the setup quarter of a slot.
  function automatic logic setup_low(input sel_pkg::sel_op_t op, input logic [3:0] bit_idx,
                                     input logic top, input logic ack);
    case (op)
      sel_pkg::OP_STOP:  setup_low = 1'b1;
      sel_pkg::OP_WRITE: setup_low = (bit_idx != sel_pkg::BIT_ACK) && !top;
      sel_pkg::OP_READ:  setup_low = (bit_idx == sel_pkg::BIT_ACK) && ack;
      default:           setup_low = 1'b0;
    endcase
  endfunction

  always_comb
  begin
    e_act_d  = e_act_q;
    e_op_d   = e_op_q;
    e_qtr_d  = e_qtr_q;
    e_bit_d  = e_bit_q;
    e_sh_d   = e_sh_q;
    e_ack_d  = e_ack_q;
    e_nack_d = e_nack_q;
    e_done_d = 1'b0;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    if (!e_act_q)
    begin
      if (cmd_go)
      begin
        e_act_d  = 1'b1;
        e_op_d   = cmd_op;
        e_sh_d   = cmd_byte;
        e_ack_d  = cmd_ack;
        e_bit_d  = '0;
        e_qtr_d  = sel_pkg::Q_SETUP;
        scl_oe_d = 1'b1;
        sda_oe_d = setup_low(cmd_op, '0, cmd_byte[7], cmd_ack);
      end
    end
    else if (tick && !(e_qtr_q == sel_pkg::Q_RISE && !scl_s))
    begin
      case (e_qtr_q)
        sel_pkg::Q_SETUP:
        begin
          e_qtr_d  = sel_pkg::Q_RISE;
          scl_oe_d = 1'b0;
        end
        sel_pkg::Q_RISE:
        begin
          e_qtr_d = sel_pkg::Q_HIGH;
          if (e_op_q == sel_pkg::OP_START)
          begin
            sda_oe_d = 1'b1;
          end
          else if (e_op_q == sel_pkg::OP_STOP)
          begin
            sda_oe_d = 1'b0;
          end
          else if (e_bit_q != sel_pkg::BIT_ACK)
          begin
            e_sh_d = {e_sh_q[6:0], sda_s};
          end
          else
          begin
            e_nack_d = sda_s;
          end
        end
        sel_pkg::Q_HIGH:
        begin
          e_qtr_d  = sel_pkg::Q_FALL;
          scl_oe_d = (e_op_q != sel_pkg::OP_STOP);
        end
        default:
        begin
          if (e_op_q == sel_pkg::OP_START || e_op_q == sel_pkg::OP_STOP ||
              e_bit_q == sel_pkg::BIT_ACK)
          begin
            e_act_d  = 1'b0;
            e_done_d = 1'b1;
          end
          else
          begin
            e_bit_d  = e_bit_q + 4'h1;
            e_qtr_d  = sel_pkg::Q_SETUP;
            sda_oe_d = setup_low(e_op_q, e_bit_q + 4'h1, e_sh_q[7], e_ack_q);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      e_act_q  <= 1'b0;
      e_op_q   <= sel_pkg::OP_STOP;
      e_qtr_q  <= sel_pkg::Q_SETUP;
      e_bit_q  <= '0;
      e_sh_q   <= '0;
      e_ack_q  <= 1'b0;
      e_nack_q <= 1'b0;
      e_done_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      e_act_q  <= e_act_d;
      e_op_q   <= e_op_d;
      e_qtr_q  <= e_qtr_d;
      e_bit_q  <= e_bit_d;
      e_sh_q   <= e_sh_d;
      e_ack_q  <= e_ack_d;
      e_nack_q <= e_nack_d;
      e_done_q <= e_done_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // ************************************************************
  // Load sequencer and configuration block parser.
  // ************************************************************

  sel_seq_t    l_q;
  sel_seq_t    l_d;
  sel_parse_t  p_q;
  sel_parse_t  p_d;
  logic [3:0]  apins_q;
  logic [3:0]  apins_d;
  logic [15:0] maddr_q;
  logic [15:0] maddr_d;
  logic [7:0]  sum_q;
  logic [7:0]  sum_d;
  logic [7:0]  alo_q;
  logic [7:0]  alo_d;
  logic [13:0] dwa_q;
  logic [13:0] dwa_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [1:0]  bidx_q;
  logic [1:0]  bidx_d;
  logic [31:0] word_q;
  logic [31:0] word_d;
  logic        err_q;
  logic        err_d;
  sel_pkg::sel_cfg_wr_t wr_q;
  sel_pkg::sel_cfg_wr_t wr_d;
  logic        wv_q;
  logic        wv_d;
  logic        ign_q;
  logic        issue;
  logic [7:0]  rx;
  logic        set_done;
  logic        set_bad;
  logic        set_nack;
  logic        set_hold;
  logic        clr_done;

  assign issue = !e_act_q && !e_done_q;
  assign rx    = e_sh_q;

  always_comb
  begin
    l_d      = l_q;
    p_d      = p_q;
    apins_d  = apins_q;
    maddr_d  = maddr_q;
    sum_d    = sum_q;
    alo_d    = alo_q;
    dwa_d    = dwa_q;
    cnt_d    = cnt_q;
    bidx_d   = bidx_q;
    word_d   = word_q;
    err_d    = err_q;
    wr_d     = wr_q;
    wv_d     = 1'b0;
    cmd_go   = 1'b0;
    cmd_op   = sel_pkg::OP_START;
    cmd_byte = '0;
    cmd_ack  = 1'b0;
    set_done = 1'b0;
    set_bad  = 1'b0;
    set_nack = 1'b0;
    set_hold = 1'b0;
    clr_done = 1'b0;
    case (l_q)
      L_START1, L_START2: cmd_op = sel_pkg::OP_START;
      L_DEVW:
      begin
        cmd_op   = sel_pkg::OP_WRITE;
        cmd_byte = sel_pkg::dev_byte(apins_q, sel_pkg::RW_WRITE);
      end
      L_MHI:
      begin
        cmd_op   = sel_pkg::OP_WRITE;
        cmd_byte = sel_pkg::EE_START[15:8];
      end
      L_MLO:
      begin
        cmd_op   = sel_pkg::OP_WRITE;
        cmd_byte = sel_pkg::EE_START[7:0];
      end
      L_DEVR:
      begin
        cmd_op   = sel_pkg::OP_WRITE;
        cmd_byte = sel_pkg::dev_byte(apins_q, sel_pkg::RW_READ);
      end
      L_READ:
      begin
        cmd_op  = sel_pkg::OP_READ;
        cmd_ack = 1'b1;
      end
      L_LAST:  cmd_op = sel_pkg::OP_READ;
      default: cmd_op = sel_pkg::OP_STOP;
    endcase
    cmd_go = issue && (l_q != L_IDLE) && (l_q != L_FIN);
    case (l_q)
      L_IDLE:
      begin
        if ((fund_reset_start || hot_reset_start) &&
            EEPROM_MODES[switch_operating_mode])
        begin
          l_d      = L_START1;
          p_d      = P_ALO;
          apins_d  = eeprom_address_pins;
          maddr_d  = sel_pkg::EE_START;
          sum_d    = '0;
          err_d    = 1'b0;
          clr_done = 1'b1;
        end
      end
      L_START1:
      begin
        if (e_done_q)
        begin
          l_d = L_DEVW;
        end
      end
      L_START2:
      begin
        if (e_done_q)
        begin
          l_d = L_DEVR;
        end
      end
      L_DEVW, L_MHI, L_MLO, L_DEVR:
      begin
        if (e_done_q && e_nack_q)
        begin
          set_nack = 1'b1;
          err_d    = 1'b1;
          l_d      = L_STOP;
        end
        else if (e_done_q)
        begin
          l_d = (l_q == L_DEVW) ? L_MHI : (l_q == L_MHI) ? L_MLO :
                (l_q == L_MLO) ? L_START2 : L_READ;
        end
      end
      L_READ:
      begin
        if (e_done_q)
        begin
          sum_d   = sum_q + rx;
          maddr_d = maddr_q + 16'h1;
          if (maddr_q == sel_pkg::EE_LAST)
          begin
            l_d = L_LAST;
          end
          case (p_q)
            P_ALO:
            begin
              alo_d = rx;
              p_d   = P_AHI;
            end
            P_AHI:
            begin
              dwa_d  = {rx[5:0], alo_q};
              bidx_d = '0;
              case (rx[7:6])
                sel_pkg::TYPE_SINGLE:
                begin
                  cnt_d = 16'h1;
                  p_d   = P_DATA;
                end
                sel_pkg::TYPE_SEQ: p_d = P_CLO;
                sel_pkg::TYPE_BAD:
                begin
                  set_bad = 1'b1;
                  err_d   = 1'b1;
                  l_d     = L_LAST;
                end
                default:
                begin
                  l_d = L_LAST;
                  if (sum_q + rx != sel_pkg::SUM_GOOD && !ign_q)
                  begin
                    set_bad = 1'b1;
                    err_d   = 1'b1;
                  end
                end
              endcase
            end
            P_CLO:
            begin
              cnt_d = {8'h00, rx};
              p_d   = P_CHI;
            end
            P_CHI:
            begin
              cnt_d = {rx, cnt_q[7:0]};
              p_d   = ({rx, cnt_q[7:0]} == 16'h0) ? P_ALO : P_DATA;
            end
            default:
            begin
              word_d = {rx, word_q[31:8]};
              bidx_d = bidx_q + 2'h1;
              if (bidx_q == sel_pkg::DW_LAST_BYTE)
              begin
                wv_d      = 1'b1;
                wr_d.addr = {dwa_q, 2'b00};
                wr_d.data = {rx, word_q[31:8]};
                dwa_d     = dwa_q + 14'h1;
                cnt_d     = cnt_q - 16'h1;
                if (cnt_q == 16'h1)
                begin
                  p_d = P_ALO;
                end
              end
            end
          endcase
        end
      end
      L_LAST:
      begin
        if (e_done_q)
        begin
          l_d = L_STOP;
        end
      end
      L_STOP:
      begin
        if (e_done_q)
        begin
          l_d = L_FIN;
        end
      end
      default:
      begin
        set_hold = err_q;
        set_done = 1'b1;
        l_d      = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      l_q     <= L_IDLE;
      p_q     <= P_ALO;
      apins_q <= '0;
      maddr_q <= '0;
      sum_q   <= '0;
      alo_q   <= '0;
      dwa_q   <= '0;
      cnt_q   <= '0;
      bidx_q  <= '0;
      word_q  <= '0;
      err_q   <= 1'b0;
      wr_q    <= '0;
      wv_q    <= 1'b0;
    end
    else
    begin
      l_q     <= l_d;
      p_q     <= p_d;
      apins_q <= apins_d;
      maddr_q <= maddr_d;
      sum_q   <= sum_d;
      alo_q   <= alo_d;
      dwa_q   <= dwa_d;
      cnt_q   <= cnt_d;
      bidx_q  <= bidx_d;
      word_q  <= word_d;
      err_q   <= err_d;
      wr_q    <= wr_d;
      wv_q    <= wv_d;
    end
  end

  // ************************************************************
  // Software registers.
  // ************************************************************

  sel_pkg::sel_stat_t stat_q;
  sel_pkg::sel_stat_t stat_d;
  logic [15:0] presc_d;
  logic        ign_d;
  logic        hold_q;
  logic        hold_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb
  begin
    presc_d = presc_q;
    ign_d   = ign_q;
    stat_d  = stat_q;
    hold_d  = hold_q;
    rdata_d = '0;
    if (fund_reset_start)
    begin
      presc_d = strap_s ? sel_pkg::PRESC_SLOW : sel_pkg::PRESC_FAST;
    end
    else if (reg_wr && reg_addr == sel_pkg::OFS_CTRL)
    begin
      presc_d = reg_wdata[15:0];
      ign_d   = reg_wdata[sel_pkg::CTRL_IGN_BIT];
    end
    if (reg_wr && reg_addr == sel_pkg::OFS_STAT)
    begin
      stat_d = stat_q & ~reg_wdata[$bits(sel_pkg::sel_stat_t)-1:0];
    end
    if (reg_wr && reg_addr == sel_pkg::OFS_SWITCH_CONTROL_REG)
    begin
      hold_d = reg_wdata[sel_pkg::SWITCH_CONTROL_REG_HOLD_BIT];
    end
    if (clr_done)
    begin
      stat_d.done = 1'b0;
    end
    stat_d.done      = stat_d.done | set_done;
    stat_d.unmapped  = stat_d.unmapped | (wv_q && !cfg_wr_mapped);
    stat_d.bad_block = stat_d.bad_block | set_bad;
    stat_d.nack      = stat_d.nack | set_nack;
    hold_d           = hold_d | set_hold;
    if (reg_rd)
    begin
      case (reg_addr)
        sel_pkg::OFS_CTRL:  rdata_d = {15'h0000, ign_q, presc_q};
        sel_pkg::OFS_STAT:  rdata_d = {27'h0000000, (l_q != L_IDLE), stat_q};
        sel_pkg::OFS_SWITCH_CONTROL_REG: rdata_d = {31'h00000000, hold_q};
        default:            rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      presc_q <= sel_pkg::PRESC_FAST;
      ign_q   <= 1'b0;
      stat_q  <= '0;
      hold_q  <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      presc_q <= presc_d;
      ign_q   <= ign_d;
      stat_q  <= stat_d;
      hold_q  <= hold_d;
      rdata_q <= rdata_d;
    end
  end

  assign scl_o         = 1'b0;
  assign sda_o         = 1'b0;
  assign scl_oe        = scl_oe_q;
  assign sda_oe        = sda_oe_q;
  assign cfg_wr        = wr_q;
  assign cfg_wr_valid  = wv_q;
  assign reg_rdata     = rdata_q;
  assign load_busy     = (l_q != L_IDLE);
  assign eeprom_done   = stat_q.done;
  assign hold_in_reset = hold_q;

endmodule
`default_nettype wire

// ### testbench/sel_loader_properties.sv
// Port-level assertions for the configuration loader.
`timescale 1ns/100ps
`default_nettype none
module sel_loader_chk (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 reg_rd,
  input wire logic                 reg_wr,
  input wire logic [31:0]          reg_rdata,
  input wire sel_pkg::sel_cfg_wr_t cfg_wr,
  input wire logic                 cfg_wr_valid,
  input wire logic                 load_busy,
  input wire logic                 eeprom_done,
  input wire logic                 hold_in_reset,
  input wire logic                 scl_o,
  input wire logic                 scl_oe,
  input wire logic                 sda_o,
  input wire logic                 sda_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  chk_word_single: assert property (cfg_wr_valid |=> !cfg_wr_valid [*8])
    else $error("write pulse too close");
  chk_word_align: assert property (cfg_wr_valid |-> cfg_wr.addr[1:0] == 2'h0)
    else $error("write address not aligned");
  chk_write_in_load: assert property (cfg_wr_valid |-> load_busy)
    else $error("write outside load");
  chk_start_clear: assert property ($rose(load_busy) |-> !eeprom_done)
    else $error("done not cleared at start");
  chk_end_done: assert property ($fell(load_busy) |-> eeprom_done)
    else $error("load ended without done");
  chk_hold_cause: assert property ($rose(hold_in_reset) && !$past(reg_wr) |-> eeprom_done)
    else $error("hold without done");
  chk_idle_quiet: assert property (!load_busy |-> !scl_oe && !sda_oe)
    else $error("bus driven while idle");
  chk_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("pin driven high");
endmodule
bind sel_loader sel_loader_chk sel_loader_chk_i (.clk(clk), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .cfg_wr(cfg_wr),
  .cfg_wr_valid(cfg_wr_valid), .load_busy(load_busy), .eeprom_done(eeprom_done),
  .hold_in_reset(hold_in_reset), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
  .sda_oe(sda_oe));
`default_nettype wire

// ### testbench/sel_eeprom.sv
// Behavioural two-wire serial EEPROM with 16-bit byte addressing.
`timescale 1ns/100ps
`default_nettype none
module sel_eeprom #(
  parameter logic [6:0] DEV = 7'h5a
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      oe
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  sh;
  logic [15:0] a;
  int          cnt;
  int          ph;
  logic        rd;
  logic        ok;
  logic        ack;
  initial oe = 1'b0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  // Start or repeated start resets the byte framing; stop releases the line.
  always @(negedge sda)
    if (scl)
    begin
      cnt = -1;
      ph = 0;
      rd = 1'b0;
      oe = 1'b0;
      ok = 1'b1;
    end
  always @(posedge sda)
    if (scl)
    begin
      ok = 1'b0;
      oe = 1'b0;
    end
  always @(posedge scl)
    if (rd)
      ack = !sda;
    else
      sh = {sh[6:0], sda};
  always @(negedge scl)
    if (ok)
    begin
      cnt = cnt + 1;
      if (cnt < 8)
        oe = rd && !mem[a][7-cnt];
      else if (cnt == 8)
      begin
        oe = 1'b0;
        if (!rd)
        begin
          if (ph == 0)
            ok = (sh[7:1] == DEV);
          if (ph == 1)
            a[15:8] = sh;
          if (ph == 2)
            a[7:0] = sh;
          rd = (ph == 0) && sh[0];
          ph = ph + 32'(!rd);
          oe = ok;
        end
      end
      else
      begin
        cnt = 0;
        oe = 1'b0;
        if (rd && ph == 5 && !ack)
          rd = 1'b0;
        else if (rd)
        begin
          if (ph == 5)
            a = a + 16'h1;
          ph = 5;
          oe = !mem[a][7];
        end
      end
    end
endmodule
`default_nettype wire

// ### testbench/sel_loader_tb.sv
// Self-checking bench for the configuration loader.
`timescale 1ns/100ps
`default_nettype none
module sel_loader_tb;
  logic                 clk = 0, reset_n = 0, fund = 0, hot = 0, strap = 0, wr = 0, rd = 0;
  logic [3:0]           mode = 4'h1, pins = 4'ha;
  logic [7:0]           addr = 8'h0;
  logic [31:0]          wdata = 32'h0, rdata;
  logic                 scl_oe, sda_oe, ee_oe, busy, done, hold, vld;
  sel_pkg::sel_cfg_wr_t cw;
  sel_pkg::sel_cfg_wr_t got [$];
  logic [7:0]           im [$] = '{8'h00, 8'h10, 8'h44, 8'h33, 8'h22, 8'h11, 8'h10, 8'h40,
    8'h02, 8'h00, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'h00, 8'h3c,
    8'h01, 8'h02, 8'h03, 8'h04};
  int                   failures = 0, n_checks = 0, cyc = 0;
  wire                  scl_w = !scl_oe;
  wire                  sda_w = !(sda_oe || ee_oe);
  wire                  mapped = cw.addr[15:12] != 4'hf;
  sel_loader sel_loader_i (.clk(clk), .reset_n(reset_n), .fund_reset_start(fund),
    .hot_reset_start(hot), .switch_operating_mode(mode), .master_slow_mode_strap(strap),
    .eeprom_address_pins(pins), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(), .sda_oe(sda_oe), .cfg_wr(cw), .cfg_wr_valid(vld), .cfg_wr_mapped(mapped),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .load_busy(busy), .eeprom_done(done), .hold_in_reset(hold));
  sel_eeprom sel_eeprom_i (.scl(scl_w), .sda(sda_w), .oe(ee_oe));
  always #2 clk = !clk;
  always @(posedge clk)
    if (vld && mapped)
      got.push_back(cw);
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      $display("[FAIL] %0t timeout", $time);
      failures++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Appends the done block and its checksum.
  task automatic img(logic [7:0] b [$]);
    logic [7:0] s;
    s = 8'hc0;
    foreach (b[i]) s += b[i];
    b.push_back(~s);
    b.push_back(8'hc0);
    foreach (b[i]) sel_eeprom_i.mem[i] = b[i];
  endtask
  task automatic load(logic [3:0] p, logic [31:0] st, logic h);
    got.delete();
    pins <= p;
    @(posedge clk);
    hot <= 1'b1;
    @(posedge clk);
    hot <= 1'b0;
    #1;
    while (busy !== 1'b0)
    begin
      @(posedge clk);
      #1;
    end
    chk({31'h0, hold}, {31'h0, h});
    rreg(sel_pkg::OFS_STAT, st);
    wreg(sel_pkg::OFS_STAT, 32'hf);
    wreg(sel_pkg::OFS_SWITCH_CONTROL_REG, 32'h0);
    $display("load test done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rreg(sel_pkg::OFS_CTRL, {16'h0, sel_pkg::PRESC_FAST});
    rreg(sel_pkg::OFS_STAT, 32'h0);
    repeat (2)
    begin
      strap <= !strap;
      repeat (6) @(posedge clk);
      fund <= 1'b1;
      @(posedge clk);
      fund <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk({31'h0, busy}, 32'h0);
      rreg(sel_pkg::OFS_CTRL, {16'h0, strap ? sel_pkg::PRESC_SLOW :
        sel_pkg::PRESC_FAST});
    end
    $display("strap test done");
    mode <= 4'h0;
    wreg(sel_pkg::OFS_CTRL, 32'h4);
    img(im);
    load(4'ha, 32'h3, 1'b0);
    chk(32'(got.size()), 32'h3);
    chk({16'h0, got[0].addr}, 32'h4000);
    chk(got[0].data, 32'h11223344);
    chk({16'h0, got[2].addr}, 32'h44);
    chk(got[2].data, 32'hb4b3b2b1);
    sel_eeprom_i.mem[2] = 8'h45;
    load(4'ha, 32'h7, 1'b1);
    wreg(sel_pkg::OFS_CTRL, 32'h10004);
    load(4'ha, 32'h3, 1'b0);
    sel_eeprom_i.mem[1] = 8'h80;
    load(4'ha, 32'h5, 1'b1);
    chk(32'(got.size()), 32'h0);
    img(im);
    load(4'h3, 32'h9, 1'b1);
    results();
  end
endmodule
`default_nettype wire
